// ==== rtl/cfc_params.svh ====
`ifndef CFC_PARAMS_SVH
`define CFC_PARAMS_SVH

// crc-16, x16+x15+x2+1, preset all ones, processed lsb first
`define CFC_CRC_INIT       16'hFFFF
// generator x16+x15+x2+1 in lsb-first (reflected) shift form
`define CFC_CRC_POLY       16'hA001
`define CFC_CRC_GOOD       16'h0000

// first byte of a frame; CFC_DEV_MSB is the top bit of the device address in the device byte
`define CFC_INIT_TYPE_BIT  7
`define CFC_REQ_MSB        6
`define CFC_REQ_LSB        4
`define CFC_SIZE_MSB       2
`define CFC_LEN_MSB        6
`define CFC_DEV_MSB        5

// request codes carried in a command's first byte
`define CFC_REQ_SGL_RD     3'h0
`define CFC_REQ_SGL_WR     3'h1
`define CFC_REQ_STK_RD     3'h2
`define CFC_REQ_STK_WR     3'h3
`define CFC_REQ_BC_RD      3'h4
`define CFC_REQ_BC_WR      3'h5
`define CFC_REQ_BC_WR_REV  3'h6

// largest number of data bytes in a write command
`define CFC_MAX_WR_BYTES   8

`endif

// ==== rtl/cfc_pkg.sv ====
package cfc_pkg;

	typedef struct packed {
		logic       sof;
		logic [7:0] data;
	} cfc_byte_s;

	typedef struct packed {
		logic        is_cmd;
		logic [2:0]  req_type;
		logic [5:0]  dev_addr;
		logic [15:0] reg_addr;
		logic [6:0]  rd_count;
	} cfc_frame_s;

	typedef struct packed {
		logic [5:0]  dev_addr;
		logic [15:0] reg_addr;
		logic [6:0]  count_m1;
	} cfc_resp_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
	} cfc_wr_s;

	typedef enum logic [2:0] {
		CFC_RX_INIT = 3'h0,
		CFC_RX_DEV  = 3'h1,
		CFC_RX_RAH  = 3'h2,
		CFC_RX_RAL  = 3'h3,
		CFC_RX_DATA = 3'h4,
		CFC_RX_CRC1 = 3'h5,
		CFC_RX_CRC2 = 3'h6
	} cfc_rx_state_e;

	typedef enum logic [3:0] {
		CFC_TX_IDLE = 4'h0,
		CFC_TX_INIT = 4'h1,
		CFC_TX_DEV  = 4'h2,
		CFC_TX_RAH  = 4'h3,
		CFC_TX_RAL  = 4'h4,
		CFC_TX_RD   = 4'h5,
		CFC_TX_WAIT = 4'h6,
		CFC_TX_LOAD = 4'h7,
		CFC_TX_CRCL = 4'h8,
		CFC_TX_CRCH = 4'h9
	} cfc_tx_state_e;

endpackage : cfc_pkg

// ==== rtl/cfc_top.sv ====
`timescale 1ns/1ps
`include "cfc_params.svh"
// What this block does
// - read command data byte holds byte count minus one, 1 to 128 bytes
// - write command stores data bytes into consecutive registers from frame address
// - response data bytes carry consecutive register values from requested address
// - 16-bit crc, generator x16+x15+x2+1, preset to all ones
// - crc over whole frame including crc bytes must give zero
// - crc checked first; bad frame gives no write and no frame_ok, though frame_info still loads its fields
// - on crc failure only the crc error is reported
// - bytes of a bad frame still relayed onward unchanged
// - each device flags its own crc fault for a corrupted frame
// - crc runs in serial order, each byte lsb first
// - transmitter appends crc over all bytes but crc, two bytes at end
// - division uses reflected generator over the running bit stream
// - command executed only when its crc is valid
// - frame: init, optional device address, register address, data, crc
// - init top bit one for command, zero for response with length minus one
module cfc_top #(
	parameter int MAX_WR = `CFC_MAX_WR_BYTES
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire cfc_pkg::cfc_byte_s rx_byte,
	input  wire logic              rx_valid,
	output logic                   rx_ready,
	output cfc_pkg::cfc_byte_s     fwd_byte,
	output logic                   fwd_valid,
	input  wire logic              fwd_ready,
	output logic                   frame_ok,
	output cfc_pkg::cfc_frame_s    frame_info,
	output logic                   crc_fault,
	input  wire logic              crc_fault_clr,
	output logic                   wr_en,
	output cfc_pkg::cfc_wr_s       wr_req,
	input  wire logic              resp_req,
	input  wire cfc_pkg::cfc_resp_s resp_info,
	output logic                   resp_busy,
	output logic                   rd_en,
	output logic [15:0]            rd_addr,
	input  wire logic [7:0]        rd_data,
	output logic [7:0]             tx_data,
	output logic                   tx_valid,
	input  wire logic              tx_ready
);

	if (MAX_WR < 1 || MAX_WR > `CFC_MAX_WR_BYTES) begin : g_bad_max_wr
		$error("cfc_top: MAX_WR out of range");
	end

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = r[0] ^ d[i] ? ((r >> 1) ^ `CFC_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : crc_byte

	logic               rx_ready_reg;
	logic               rx_fire;
	cfc_pkg::cfc_byte_s out_d_reg, skid_d_reg, out_d_next, skid_d_next;
	logic               out_v_reg, skid_v_reg, out_v_next, skid_v_next;
	assign rx_fire   = rx_valid & rx_ready_reg;
	assign rx_ready  = rx_ready_reg;
	assign fwd_byte  = out_d_reg;
	assign fwd_valid = out_v_reg;
	// every accepted byte is relayed whatever its crc
	always_comb begin
		out_v_next  = out_v_reg;
		skid_v_next = skid_v_reg;
		out_d_next  = out_d_reg;
		skid_d_next = skid_d_reg;
		if (out_v_reg && fwd_ready) begin
			if (skid_v_reg) begin
				out_d_next  = skid_d_reg;
				skid_v_next = 1'b0;
			end else begin
				out_v_next = 1'b0;
			end
		end
		if (rx_fire) begin
			if (!out_v_next) begin
				out_v_next = 1'b1;
				out_d_next = rx_byte;
			end else begin
				skid_v_next = 1'b1;
				skid_d_next = rx_byte;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_v_reg  <= 1'b0;
			skid_v_reg <= 1'b0;
			out_d_reg  <= '0;
			skid_d_reg <= '0;
		end else begin
			out_v_reg  <= out_v_next;
			skid_v_reg <= skid_v_next;
			out_d_reg  <= out_d_next;
			skid_d_reg <= skid_d_next;
		end
	end

	// receive parser
	cfc_pkg::cfc_rx_state_e rx_st_reg, rx_st;
	logic [15:0] crc_reg, crc_in, crc_now;
	logic [6:0]  dlast_reg, didx_reg;
	logic        is_cmd_reg;
	logic [2:0]  req_reg, req_in;
	logic [5:0]  dev_reg;
	logic [15:0] radr_reg;
	logic [6:0]  rdcnt_reg;
	logic [7:0]  wbuf [MAX_WR];
	logic        is_wr, is_rd, has_dev, crc_good, wr_go;
	// a start-of-frame byte always resynchronises the parser
	assign rx_st   = rx_byte.sof ? cfc_pkg::CFC_RX_INIT : rx_st_reg;
	assign crc_in  = (rx_st == cfc_pkg::CFC_RX_INIT) ? `CFC_CRC_INIT : crc_reg;
	assign crc_now = crc_byte(crc_in, rx_byte.data);
	// residue over whole frame must be zero
	assign crc_good = crc_now == `CFC_CRC_GOOD;
	assign req_in  = rx_byte.data[`CFC_REQ_MSB:`CFC_REQ_LSB];
	assign is_wr   = is_cmd_reg && (req_reg == `CFC_REQ_SGL_WR || req_reg == `CFC_REQ_STK_WR
		|| req_reg == `CFC_REQ_BC_WR || req_reg == `CFC_REQ_BC_WR_REV);
	assign is_rd   = req_in == `CFC_REQ_SGL_RD || req_in == `CFC_REQ_STK_RD || req_in == `CFC_REQ_BC_RD;
	// only single-device commands omit nothing; responses always carry it
	assign has_dev = !rx_byte.data[`CFC_INIT_TYPE_BIT] || req_in == `CFC_REQ_SGL_RD
		|| req_in == `CFC_REQ_SGL_WR;
	// writes start only from a frame whose crc checked good
	assign wr_go   = rx_fire && rx_st == cfc_pkg::CFC_RX_CRC2 && crc_good && is_wr;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_reg  <= cfc_pkg::CFC_RX_INIT;
			crc_reg    <= `CFC_CRC_INIT;
			dlast_reg  <= '0;
			didx_reg   <= '0;
			is_cmd_reg <= 1'b0;
			req_reg    <= '0;
			dev_reg    <= '0;
			radr_reg   <= '0;
			rdcnt_reg  <= '0;
		end else if (rx_fire) begin
			crc_reg <= crc_now;
			unique case (rx_st)
				cfc_pkg::CFC_RX_INIT: begin
					// frame type and length from first byte
					is_cmd_reg <= rx_byte.data[`CFC_INIT_TYPE_BIT];
					req_reg    <= req_in;
					if (!rx_byte.data[`CFC_INIT_TYPE_BIT])
						dlast_reg <= rx_byte.data[`CFC_LEN_MSB:0];
					else if (is_rd)
						dlast_reg <= '0;
					else
						dlast_reg <= {4'h0, rx_byte.data[`CFC_SIZE_MSB:0]};
					dev_reg   <= '0;
					rx_st_reg <= has_dev ? cfc_pkg::CFC_RX_DEV : cfc_pkg::CFC_RX_RAH;
				end
				cfc_pkg::CFC_RX_DEV: begin
					dev_reg   <= rx_byte.data[`CFC_DEV_MSB:0];
					rx_st_reg <= cfc_pkg::CFC_RX_RAH;
				end
				cfc_pkg::CFC_RX_RAH: begin
					radr_reg[15:8] <= rx_byte.data;
					rx_st_reg      <= cfc_pkg::CFC_RX_RAL;
				end
				cfc_pkg::CFC_RX_RAL: begin
					radr_reg[7:0] <= rx_byte.data;
					didx_reg      <= '0;
					rx_st_reg     <= cfc_pkg::CFC_RX_DATA;
				end
				cfc_pkg::CFC_RX_DATA: begin
					// read count byte, count minus one
					rdcnt_reg <= rx_byte.data[6:0];
					didx_reg  <= didx_reg + 7'h01;
					rx_st_reg <= (didx_reg == dlast_reg) ? cfc_pkg::CFC_RX_CRC1 : cfc_pkg::CFC_RX_DATA;
				end
				cfc_pkg::CFC_RX_CRC1: rx_st_reg <= cfc_pkg::CFC_RX_CRC2;
				cfc_pkg::CFC_RX_CRC2: rx_st_reg <= cfc_pkg::CFC_RX_INIT;
				default:              rx_st_reg <= cfc_pkg::CFC_RX_INIT;
			endcase
		end
	end

	// write data held until the crc verdict; no reset, contents only read after a good frame
	always_ff @(posedge clk) begin
		if (rx_fire && rx_st == cfc_pkg::CFC_RX_DATA && didx_reg < 7'(MAX_WR))
			wbuf[didx_reg[2:0]] <= rx_byte.data;
	end
	// verdict only at frame end, nothing acted on before
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_ok   <= 1'b0;
			frame_info <= '0;
		end else begin
			frame_ok <= rx_fire && rx_st == cfc_pkg::CFC_RX_CRC2 && crc_good;
			if (rx_fire && rx_st == cfc_pkg::CFC_RX_CRC2)
				frame_info <= '{is_cmd: is_cmd_reg, req_type: req_reg, dev_addr: dev_reg,
					reg_addr: radr_reg, rd_count: rdcnt_reg};
		end
	end
	// sticky fault, a new error wins over a clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			crc_fault <= 1'b0;
		// only the crc error is raised for a bad frame
		else if (rx_fire && rx_st == cfc_pkg::CFC_RX_CRC2 && !crc_good)
			crc_fault <= 1'b1;
		else if (crc_fault_clr)
			crc_fault <= 1'b0;
	end

	// write burst; receive stalls meanwhile so the buffer is not overwritten
	logic       wr_busy_reg, busy_next;
	logic [2:0] widx_reg, wlast_reg;
	assign busy_next = wr_go || (wr_busy_reg && widx_reg != wlast_reg);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_busy_reg <= 1'b0;
			widx_reg    <= '0;
			wlast_reg   <= '0;
			wr_en       <= 1'b0;
			wr_req      <= '0;
		end else begin
			wr_busy_reg <= busy_next;
			wr_en       <= wr_busy_reg;
			if (wr_go) begin
				widx_reg  <= '0;
				wlast_reg <= dlast_reg[2:0];
			end else if (wr_busy_reg) begin
				wr_req.addr <= radr_reg + {13'h0000, widx_reg};
				wr_req.data <= wbuf[widx_reg];
				widx_reg    <= widx_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rx_ready_reg <= 1'b0;
		else
			rx_ready_reg <= !skid_v_next && !busy_next;
	end
	// response transmitter
	cfc_pkg::cfc_tx_state_e tx_st_reg;
	cfc_pkg::cfc_resp_s     rsp_reg;
	logic [15:0] tcrc_reg;
	logic [6:0]  tidx_reg;
	logic        slot_free;
	assign slot_free = !tx_valid || tx_ready;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			resp_busy <= 1'b0;
			tx_st_reg <= cfc_pkg::CFC_TX_IDLE;
			rsp_reg   <= '0;
			tcrc_reg  <= `CFC_CRC_INIT;
			tidx_reg  <= '0;
			tx_valid  <= 1'b0;
			tx_data   <= '0;
			rd_en     <= 1'b0;
			rd_addr   <= '0;
		end else begin
			rd_en <= 1'b0;
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			unique case (tx_st_reg)
				cfc_pkg::CFC_TX_IDLE: if (resp_req) begin
					resp_busy <= 1'b1;
					rsp_reg   <= resp_info;
					tcrc_reg  <= `CFC_CRC_INIT;
					tidx_reg  <= '0;
					tx_st_reg <= cfc_pkg::CFC_TX_INIT;
				end
				cfc_pkg::CFC_TX_INIT: if (slot_free) begin
					// response marker and length minus one
					tx_data   <= {1'b0, rsp_reg.count_m1};
					tx_valid  <= 1'b1;
					tcrc_reg  <= crc_byte(tcrc_reg, {1'b0, rsp_reg.count_m1});
					tx_st_reg <= cfc_pkg::CFC_TX_DEV;
				end
				cfc_pkg::CFC_TX_DEV: if (slot_free) begin
					tx_data   <= {2'h0, rsp_reg.dev_addr};
					tx_valid  <= 1'b1;
					tcrc_reg  <= crc_byte(tcrc_reg, {2'h0, rsp_reg.dev_addr});
					tx_st_reg <= cfc_pkg::CFC_TX_RAH;
				end
				cfc_pkg::CFC_TX_RAH: if (slot_free) begin
					tx_data   <= rsp_reg.reg_addr[15:8];
					tx_valid  <= 1'b1;
					tcrc_reg  <= crc_byte(tcrc_reg, rsp_reg.reg_addr[15:8]);
					tx_st_reg <= cfc_pkg::CFC_TX_RAL;
				end
				cfc_pkg::CFC_TX_RAL: if (slot_free) begin
					tx_data   <= rsp_reg.reg_addr[7:0];
					tx_valid  <= 1'b1;
					tcrc_reg  <= crc_byte(tcrc_reg, rsp_reg.reg_addr[7:0]);
					tx_st_reg <= cfc_pkg::CFC_TX_RD;
				end
				// read is issued only with the slot free, so the loaded byte never overruns
				cfc_pkg::CFC_TX_RD: if (slot_free) begin
					// consecutive registers from the requested address
					rd_en     <= 1'b1;
					rd_addr   <= rsp_reg.reg_addr + {9'h000, tidx_reg};
					tx_st_reg <= cfc_pkg::CFC_TX_WAIT;
				end
				cfc_pkg::CFC_TX_WAIT: tx_st_reg <= cfc_pkg::CFC_TX_LOAD;
				cfc_pkg::CFC_TX_LOAD: begin
					tx_data   <= rd_data;
					tx_valid  <= 1'b1;
					tcrc_reg  <= crc_byte(tcrc_reg, rd_data);
					tidx_reg  <= tidx_reg + 7'h01;
					tx_st_reg <= (tidx_reg == rsp_reg.count_m1) ? cfc_pkg::CFC_TX_CRCL : cfc_pkg::CFC_TX_RD;
				end
				// remainder appended, low byte first to keep bit-stream order
				cfc_pkg::CFC_TX_CRCL: if (slot_free) begin
					tx_data   <= tcrc_reg[7:0];
					tx_valid  <= 1'b1;
					tx_st_reg <= cfc_pkg::CFC_TX_CRCH;
				end
				cfc_pkg::CFC_TX_CRCH: if (slot_free) begin
					tx_data   <= tcrc_reg[15:8];
					tx_valid  <= 1'b1;
					resp_busy <= 1'b0;
					tx_st_reg <= cfc_pkg::CFC_TX_IDLE;
				end
				default: tx_st_reg <= cfc_pkg::CFC_TX_IDLE;
			endcase
		end
	end

endmodule : cfc_top

// ==== verif/cfc_top_sva.sv ====
`timescale 1ns/1ps
module cfc_top_sva (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               rx_valid,
	input wire logic               rx_ready,
	input wire cfc_pkg::cfc_byte_s fwd_byte,
	input wire logic               fwd_valid,
	input wire logic               fwd_ready,
	input wire logic               frame_ok,
	input wire logic               crc_fault,
	input wire logic               crc_fault_clr,
	input wire logic               wr_en,
	input wire cfc_pkg::cfc_wr_s   wr_req,
	input wire logic [7:0]         tx_data,
	input wire logic               tx_valid,
	input wire logic               tx_ready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_ok_pulse: assert property (frame_ok |=> !frame_ok)
		else $error("frame_ok held too long");
	a_ok_no_fault: assert property (frame_ok |-> !$rose(crc_fault))
		else $error("fault raised on good frame");
	a_fwd_take: assert property (rx_valid && rx_ready |=> fwd_valid)
		else $error("taken byte not relayed");
	a_fwd_hold: assert property (fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_byte))
		else $error("relayed byte lost in stall");
	a_fault_sticky: assert property (crc_fault && !crc_fault_clr |=> crc_fault)
		else $error("fault dropped without clear");
	a_wr_after_ok: assert property ($rose(wr_en) |-> $past(frame_ok))
		else $error("write without good frame");
	a_wr_consec: assert property (wr_en && $past(wr_en) |-> wr_req.addr == $past(wr_req.addr) + 16'h0001)
		else $error("write address not consecutive");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("response byte changed in stall");
endmodule : cfc_top_sva

bind cfc_top cfc_top_sva u_cfc_top_sva (.clk, .rst_n, .rx_valid, .rx_ready, .fwd_byte, .fwd_valid,
	.fwd_ready, .frame_ok, .crc_fault, .crc_fault_clr, .wr_en, .wr_req, .tx_data, .tx_valid, .tx_ready);

// ==== verif/cfc_reg_model.sv ====
`timescale 1ns/1ps
module cfc_reg_model (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             wr_en,
	input  wire cfc_pkg::cfc_wr_s wr_req,
	input  wire logic             rd_en,
	input  wire logic [15:0]      rd_addr,
	output logic [7:0]            rd_data
);
	logic [7:0] mem [0:65535];
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_req.addr] <= wr_req.data;
		end
	end
	// answer next cycle
	// outside that cycle the data flips, so a late sample is caught
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= rd_en ? mem[rd_addr] : ~rd_data;
		end
	end
endmodule : cfc_reg_model

// ==== verif/tb_cfc_top.sv ====
`timescale 1ns/1ps
module tb_cfc_top;
	logic                clk;
	logic                rst_n;
	logic                rx_valid, rx_ready, fwd_valid, fwd_ready, frame_ok, crc_fault, crc_fault_clr;
	logic                wr_en, resp_req, resp_busy, rd_en, tx_valid, tx_ready;
	logic [15:0]         rd_addr;
	logic [7:0]          rd_data, tx_data;
	logic [7:0]          fq[$], tq[$];
	cfc_pkg::cfc_byte_s  rx_byte, fwd_byte;
	cfc_pkg::cfc_frame_s frame_info;
	cfc_pkg::cfc_wr_s    wr_req;
	cfc_pkg::cfc_wr_s    wq[$];
	cfc_pkg::cfc_resp_s  resp_info;
	int                  ok_n, error_cnt, n_checks;

	cfc_top u_cfc_top (.clk, .rst_n, .rx_byte, .rx_valid, .rx_ready, .fwd_byte, .fwd_valid, .fwd_ready,
		.frame_ok, .frame_info, .crc_fault, .crc_fault_clr, .wr_en, .wr_req, .resp_req, .resp_info,
		.resp_busy, .rd_en, .rd_addr, .rd_data, .tx_data, .tx_valid, .tx_ready);
	cfc_reg_model u_cfc_reg_model (.clk, .rst_n, .wr_en, .wr_req, .rd_en, .rd_addr, .rd_data);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// monitor reads pre-edge values, so no race with the design
	always @(posedge clk) begin
		if (fwd_valid && fwd_ready) fq.push_back(fwd_byte.data);
		if (tx_valid && tx_ready) tq.push_back(tx_data);
		if (wr_en) wq.push_back(wr_req);
		if (frame_ok) ok_n++;
	end

	task chk(input logic [31:0] got, input logic [31:0] want);
		n_checks++;
		if (got !== want) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk

	task cmpq(input logic [7:0] got[$], input logic [7:0] want[$]);
		chk(got.size(), want.size());
		foreach (want[i]) chk(got[i], want[i]);
	endtask : cmpq

	function automatic logic [15:0] crc(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc

	function automatic void seal(ref logic [7:0] q[$]);
		logic [15:0] c;
		c = crc(q);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endfunction : seal

	task automatic send(input logic [7:0] q[$]);
		// start on a rising edge; each byte stands until it is taken
		@(posedge clk);
		foreach (q[i]) begin
			rx_byte <= {i == 0, q[i]};
			rx_valid <= 1'b1;
			do @(negedge clk); while (!rx_ready);
			@(posedge clk);
		end
		rx_valid <= 1'b0;
	endtask : send

	task t_read;
		logic [7:0] q[$];
		for (int k = 0; k < 2; k++) begin
			q = '{8'h80, k ? 8'h2A : 8'h00, 8'h02, 8'h0F, k ? 8'h7F : 8'h0B};
			seal(q);
			if (k == 0) chk({q[5], q[6]}, 16'hC029);
			ok_n = 0;
			wq = {};
			fq = {};
			send(q);
			repeat (8) @(negedge clk);
			chk(ok_n, 1);
			chk(frame_info.is_cmd, 1);
			chk(frame_info.dev_addr, k ? 6'h2A : 6'h00);
			chk(frame_info.reg_addr, 16'h020F);
			chk(frame_info.rd_count, k ? 7'h7F : 7'h0B);
			chk(wq.size(), 0);
			cmpq(fq, q);
		end
	endtask : t_read

	task t_write;
		logic [7:0] q[$];
		int         p;
		for (int k = 0; k < 3; k++) begin
			// stack write, single write with its device byte, reserved code that must not write
			q = '{k == 0 ? 8'hB3 : (k == 1 ? 8'h93 : 8'hF3), 8'h03, 8'h00, 8'h02, 8'hB7, 8'h78, 8'hBC};
			p = k == 1 ? 4 : 3;
			if (k == 1) q.insert(1, 8'h02);
			seal(q);
			ok_n = 0;
			wq = {};
			send(q);
			repeat (10) @(negedge clk);
			chk(ok_n, 1);
			chk(frame_info.req_type, k == 0 ? 3'h3 : (k == 1 ? 3'h1 : 3'h7));
			chk(wq.size(), k == 2 ? 0 : 4);
			foreach (wq[i]) chk(wq[i], {16'h0300 + i[15:0], q[p+i]});
		end
	endtask : t_write

	task t_bad;
		logic [7:0] q[$];
		q = '{8'hB3, 8'h03, 8'h00, 8'h02, 8'hB7, 8'h78, 8'hBC};
		seal(q);
		q[8] = ~q[8];
		ok_n = 0;
		wq = {};
		fq = {};
		@(posedge clk);
		fwd_ready <= 1'b0;
		fork
			send(q);
			begin
				repeat (12) @(posedge clk);
				fwd_ready <= 1'b1;
			end
		join
		repeat (10) @(negedge clk);
		chk(crc_fault, 1);
		chk(ok_n, 0);
		chk(wq.size(), 0);
		cmpq(fq, q);
		@(posedge clk);
		crc_fault_clr <= 1'b1;
		@(posedge clk);
		crc_fault_clr <= 1'b0;
		repeat (2) @(negedge clk);
		chk(crc_fault, 0);
		// clear still high at the edge that ends the bad frame: the new error must win
		@(posedge clk);
		crc_fault_clr <= 1'b1;
		send(q);
		crc_fault_clr <= 1'b0;
		@(negedge clk);
		chk(crc_fault, 1);
	endtask : t_bad

	task t_resp;
		logic [7:0] e[$];
		e = '{8'h03, 8'h05, 8'h03, 8'h00, 8'h02, 8'hB7, 8'h78, 8'hBC};
		seal(e);
		tq = {};
		@(posedge clk);
		resp_info <= {6'h05, 16'h0300, 7'h03};
		resp_req <= 1'b1;
		tx_ready <= 1'b0;
		@(posedge clk);
		resp_req <= 1'b0;
		repeat (6) @(posedge clk);
		tx_ready <= 1'b1;
		do @(negedge clk); while (resp_busy);
		repeat (3) @(negedge clk);
		cmpq(tq, e);
		chk(crc(tq), 16'h0000);
		// the same frame received as a response relayed from the device above
		ok_n = 0;
		wq = {};
		send(e);
		repeat (4) @(negedge clk);
		chk(ok_n, 1);
		chk(frame_info.is_cmd, 0);
		chk(frame_info.dev_addr, 6'h05);
		chk(frame_info.reg_addr, 16'h0300);
		chk(wq.size(), 0);
	endtask : t_resp

	task finish_test;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	initial begin
		rst_n = 1'b0;
		rx_byte = '0;
		rx_valid = 1'b0;
		fwd_ready = 1'b1;
		crc_fault_clr = 1'b0;
		resp_req = 1'b0;
		resp_info = '0;
		tx_ready = 1'b1;
		error_cnt = 0;
		n_checks = 0;
		ok_n = 0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_read();
		t_write();
		t_bad();
		t_resp();
		finish_test();
	end

	// whole run needs a few hundred cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		finish_test();
	end
endmodule : tb_cfc_top
